// ### inc/asc_map.svh
// Register offsets, field positions and reset values of the converter conditioner.
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ASC_OFF_CTRL    8'h00
`define ASC_OFF_STATUS  8'h04
`define ASC_OFF_SETP    8'h08
`define ASC_OFF_RESULT  8'h0C
`define ASC_OFF_SETTLE  8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ASC_CTRL_INIT   0
`define ASC_CTRL_DEACT  1
`define ASC_CTRL_READ   2
`define ASC_CTRL_RCHAN  3
`define ASC_CTRL_REVA   4
`define ASC_SETP_VAL_HI 15
`define ASC_SETP_SEL_HI 17
`define ASC_SETP_SEL_LO 16
`define ASC_SETP_CHAN   18

// ----------------------------------------------------------------
// Reset values, limits and bus codes
// ----------------------------------------------------------------
`define ASC_AVG_RST     8'h01
`define ASC_AVG_MAX     8'hFE
`define ASC_ZERO_RST    16'h0000
`define ASC_ZERO_MAX    16'hFFFE
`define ASC_MASK_RST    16'hFFFF
`define ASC_SETTLE_RST  16'h000A
`define ASC_RES_MAX     32'h0000_0FFF
`define ASC_RES_SAT     12'hFFF
`define ASC_STRB_FULL   4'hF
`define ASC_RESP_OKAY   2'h0
`define ASC_RESP_SLVERR 2'h2

`endif

// ### inc/asc_pkg.sv
// Types shared by the converter conditioner modules.
package asc_pkg;

	// ----------------------------------------------------------------
	// Sequencer states, Gray coded along the read path
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ASC_IDLE   = 3'h0,
		ASC_SETTLE = 3'h1,
		ASC_CONV   = 3'h3,
		ASC_MASK   = 3'h2,
		ASC_ACCUM  = 3'h6,
		ASC_DIV    = 3'h7
	} asc_state_t;

	// ----------------------------------------------------------------
	// Set-parameters selector
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ASC_SEL_AVG   = 2'h0,
		ASC_SEL_ZERO  = 2'h1,
		ASC_SEL_NOISE = 2'h2
	} asc_sel_t;

endpackage

// ### verilog/asc_axil.sv
// AXI4-Lite slave front end for the converter conditioner registers.
`timescale 1ns/1ns
`include "asc_map.svh"

module asc_axil #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	input  wire logic              wr_ok,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok
);

	logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic [31:0]       w_data_q, w_data_d, rdata_q, rdata_d;
	logic [3:0]        w_strb_q, w_strb_d;
	logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
	logic              wr_fire;

	assign awready = !aw_full_q;
	assign wready  = !w_full_q;
	assign arready = !rvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;
	assign rd_addr = araddr;
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	// Partial writes are answered but ignored; every register is a whole command word.
	assign wr_en   = wr_fire && (w_strb_q == `ASC_STRB_FULL);
	assign wr_addr = aw_addr_q;
	assign wr_data = w_data_q;

	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d  = w_full_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (awvalid && !aw_full_q) begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && !w_full_q) begin
			w_full_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (wr_fire) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_ok ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
		end else if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		if (arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rdata_d  = rd_ok ? rd_data : 32'h0000_0000;
			rresp_d  = rd_ok ? `ASC_RESP_OKAY : `ASC_RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `ASC_RESP_OKAY;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `ASC_RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q  <= w_full_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

endmodule // asc_axil

// ### verilog/asc_div.sv
// Iterative unsigned restoring divider, one quotient bit per clock.
`timescale 1ns/1ns

module asc_div #(
	parameter int NUM_W = 32,
	parameter int DEN_W = 8
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             start,
	input  wire logic [NUM_W-1:0] num,
	input  wire logic [DEN_W-1:0] den,
	output logic                  done,
	output logic [NUM_W-1:0]      quot
);

	localparam int CNT_W = $clog2(NUM_W) + 1;

	logic             busy_q, busy_d, done_q, done_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [DEN_W:0]   rem_q, rem_d, rem_s;
	logic [NUM_W-1:0] quo_q, quo_d;
	logic [DEN_W-1:0] den_q, den_d;

	assign done = done_q;
	assign quot = quo_q;

	always_comb begin
		busy_d = busy_q;
		done_d = 1'b0;
		cnt_d  = cnt_q;
		rem_d  = rem_q;
		quo_d  = quo_q;
		den_d  = den_q;
		rem_s  = {rem_q[DEN_W-1:0], quo_q[NUM_W-1]};
		if (start && !busy_q) begin
			busy_d = 1'b1;
			cnt_d  = CNT_W'(NUM_W);
			rem_d  = '0;
			quo_d  = num;
			den_d  = den;
		end else if (busy_q) begin
			// Truncating unsigned division: the remainder is simply dropped.
			if (rem_s >= {1'b0, den_q}) begin
				rem_d = rem_s - {1'b0, den_q};
				quo_d = {quo_q[NUM_W-2:0], 1'b1};
			end else begin
				rem_d = rem_s;
				quo_d = {quo_q[NUM_W-2:0], 1'b0};
			end
			cnt_d = cnt_q - CNT_W'(1);
			if (cnt_q == CNT_W'(1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			cnt_q  <= '0;
			rem_q  <= '0;
			quo_q  <= '0;
			den_q  <= '0;
		end else begin
			busy_q <= busy_d;
			done_q <= done_d;
			cnt_q  <= cnt_d;
			rem_q  <= rem_d;
			quo_q  <= quo_d;
			den_q  <= den_d;
		end
	end

endmodule // asc_div

// ### verilog/asc_top.sv
// Converter sample conditioner: command registers, read sequencer and averaging.
`timescale 1ns/1ns
`include "asc_map.svh"

module asc_top #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 12,
	parameter int ACC_W  = 32,
	parameter int AVG_W  = 8,
	parameter int PAR_W  = 16
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   io_adc_sel,
	output logic                   adc_start,
	output logic                   adc_chan,
	input  wire logic              adc_done,
	input  wire logic [DATA_W-1:0] adc_data
);

	// ----------------------------------------------------------------
	// Bus front end and decode
	// ----------------------------------------------------------------
	logic              wr_en, wr_ok, rd_ok;
	logic [ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0]       wr_data, rd_data;
	logic              wr_ctrl, wr_setp, wr_settle;
	logic              cmd_init, cmd_deact, cmd_read;

	asc_axil #(.ADDR_W(ADDR_W)) u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_ok   (wr_ok),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	assign wr_ok     = (wr_addr == `ASC_OFF_CTRL) || (wr_addr == `ASC_OFF_SETP) ||
	                   (wr_addr == `ASC_OFF_SETTLE);
	assign wr_ctrl   = wr_en && (wr_addr == `ASC_OFF_CTRL);
	assign wr_setp   = wr_en && (wr_addr == `ASC_OFF_SETP);
	assign wr_settle = wr_en && (wr_addr == `ASC_OFF_SETTLE);
	assign cmd_init  = wr_ctrl && wr_data[`ASC_CTRL_INIT];
	assign cmd_deact = wr_ctrl && wr_data[`ASC_CTRL_DEACT];
	assign cmd_read  = wr_ctrl && wr_data[`ASC_CTRL_READ];

	// ----------------------------------------------------------------
	// Configuration state
	// ----------------------------------------------------------------
	logic             init_q, init_d, rev_a_q, rev_a_d;
	logic [PAR_W-1:0] settle_q, settle_d;
	logic [AVG_W-1:0] avg_q [2];
	logic [AVG_W-1:0] avg_d [2];
	logic [PAR_W-1:0] zero_q [2];
	logic [PAR_W-1:0] zero_d [2];
	logic [PAR_W-1:0] mask_q [2];
	logic [PAR_W-1:0] mask_d [2];
	logic             setp_ch;
	logic [PAR_W-1:0] setp_val;
	asc_pkg::asc_sel_t setp_sel;
	asc_pkg::asc_state_t state_q, state_d;

	assign setp_ch  = wr_data[`ASC_SETP_CHAN];
	assign setp_val = wr_data[`ASC_SETP_VAL_HI:0];
	assign setp_sel = asc_pkg::asc_sel_t'(wr_data[`ASC_SETP_SEL_HI:`ASC_SETP_SEL_LO]);

	always_comb begin
		init_d   = init_q;
		rev_a_d  = rev_a_q;
		settle_d = settle_q;
		avg_d    = avg_q;
		zero_d   = zero_q;
		mask_d   = mask_q;
		if (wr_ctrl) begin
			rev_a_d = wr_data[`ASC_CTRL_REVA];
			if (cmd_deact) begin
				init_d = 1'b0;
			end else if (cmd_init) begin
				init_d = 1'b1;
			end
		end
		if (wr_settle) begin
			settle_d = wr_data[PAR_W-1:0];
		end
		// Set-parameters values never change under a running read, so a read sees one set of values.
		if (wr_setp && init_q && (state_q == asc_pkg::ASC_IDLE)) begin
			unique case (setp_sel)
				asc_pkg::ASC_SEL_AVG: begin
					if ((setp_val[PAR_W-1:AVG_W] == '0) && (setp_val[AVG_W-1:0] != '0) &&
					    (setp_val[AVG_W-1:0] <= `ASC_AVG_MAX)) begin
						avg_d[setp_ch] = setp_val[AVG_W-1:0];
					end
				end
				asc_pkg::ASC_SEL_ZERO: begin
					if (setp_val <= `ASC_ZERO_MAX) begin
						zero_d[setp_ch] = setp_val;
					end
				end
				asc_pkg::ASC_SEL_NOISE: mask_d[setp_ch] = setp_val;
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_q   <= 1'b0;
			rev_a_q  <= 1'b0;
			settle_q <= `ASC_SETTLE_RST;
			for (int i = 0; i < 2; i++) begin
				avg_q[i]  <= `ASC_AVG_RST;
				zero_q[i] <= `ASC_ZERO_RST;
				mask_q[i] <= `ASC_MASK_RST;
			end
		end else begin
			init_q   <= init_d;
			rev_a_q  <= rev_a_d;
			settle_q <= settle_d;
			avg_q    <= avg_d;
			zero_q   <= zero_d;
			mask_q   <= mask_d;
		end
	end

	assign io_adc_sel = init_q;

	// ----------------------------------------------------------------
	// Read sequencer
	// ----------------------------------------------------------------
	logic             chan_q, chan_d, start_q, start_d, done_q, done_d;
	logic [ACC_W-1:0] acc_q, acc_d;
	logic [PAR_W-1:0] samp_q, samp_d, wait_q, wait_d, corr;
	logic [AVG_W-1:0] cnt_q, cnt_d;
	logic [DATA_W-1:0] result_q, result_d;
	logic             div_start, div_done;
	logic [ACC_W-1:0] div_quot;
	logic             rd_chan;

	assign rd_chan   = wr_data[`ASC_CTRL_RCHAN];
	assign corr      = (samp_q < zero_q[chan_q]) ? zero_q[chan_q] : samp_q - zero_q[chan_q];
	assign div_start = (state_q == asc_pkg::ASC_ACCUM) && ((cnt_q + 8'h01) >= avg_q[chan_q]);

	asc_div #(.NUM_W(ACC_W), .DEN_W(AVG_W)) u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (div_start),
		.num     (acc_d),
		.den     (avg_q[chan_q]),
		.done    (div_done),
		.quot    (div_quot)
	);

	always_comb begin
		state_d  = state_q;
		chan_d   = chan_q;
		start_d  = 1'b0;
		done_d   = done_q;
		acc_d    = acc_q;
		samp_d   = samp_q;
		wait_d   = wait_q;
		cnt_d    = cnt_q;
		result_d = result_q;
		unique case (state_q)
			asc_pkg::ASC_IDLE: begin
				if (cmd_read && init_q && !cmd_deact) begin
					acc_d  = '0;
					cnt_d  = '0;
					done_d = 1'b0;
					chan_d = rd_chan;
					if (rev_a_q && (rd_chan != chan_q) && (settle_q != '0)) begin
						wait_d  = settle_q;
						state_d = asc_pkg::ASC_SETTLE;
					end else begin
						start_d = 1'b1;
						state_d = asc_pkg::ASC_CONV;
					end
				end
			end
			asc_pkg::ASC_SETTLE: begin
				wait_d = wait_q - 16'h0001;
				if (wait_q == 16'h0001) begin
					start_d = 1'b1;
					state_d = asc_pkg::ASC_CONV;
				end
			end
			asc_pkg::ASC_CONV: begin
				if (adc_done) begin
					samp_d  = PAR_W'(adc_data);
					state_d = asc_pkg::ASC_MASK;
				end
			end
			asc_pkg::ASC_MASK: begin
				samp_d  = samp_q & mask_q[chan_q];
				state_d = asc_pkg::ASC_ACCUM;
			end
			asc_pkg::ASC_ACCUM: begin
				acc_d = acc_q + ACC_W'(corr);
				cnt_d = cnt_q + 8'h01;
				if (div_start) begin
					state_d = asc_pkg::ASC_DIV;
				end else begin
					start_d = 1'b1;
					state_d = asc_pkg::ASC_CONV;
				end
			end
			asc_pkg::ASC_DIV: begin
				if (div_done) begin
					// A large offset can push the mean past 12 bits; the answer saturates.
					result_d = (div_quot > `ASC_RES_MAX) ? `ASC_RES_SAT : div_quot[DATA_W-1:0];
					done_d   = 1'b1;
					state_d  = asc_pkg::ASC_IDLE;
				end
			end
			default: state_d = asc_pkg::ASC_IDLE;
		endcase
		if (!init_q && (state_q != asc_pkg::ASC_IDLE)) begin
			state_d = asc_pkg::ASC_IDLE;
			start_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q  <= asc_pkg::ASC_IDLE;
			chan_q   <= 1'b0;
			start_q  <= 1'b0;
			done_q   <= 1'b0;
			acc_q    <= '0;
			samp_q   <= '0;
			wait_q   <= '0;
			cnt_q    <= '0;
			result_q <= '0;
		end else begin
			state_q  <= state_d;
			chan_q   <= chan_d;
			start_q  <= start_d;
			done_q   <= done_d;
			acc_q    <= acc_d;
			samp_q   <= samp_d;
			wait_q   <= wait_d;
			cnt_q    <= cnt_d;
			result_q <= result_d;
		end
	end

	assign adc_start = start_q;
	assign adc_chan  = chan_q;

	// ----------------------------------------------------------------
	// Register read-back
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		unique case (rd_addr)
			`ASC_OFF_CTRL:   rd_data[`ASC_CTRL_REVA] = rev_a_q;
			`ASC_OFF_STATUS: rd_data[3:0] = {done_q, chan_q, (state_q != asc_pkg::ASC_IDLE),
			                                 init_q};
			`ASC_OFF_SETP:   rd_data = 32'h0000_0000;
			`ASC_OFF_RESULT: rd_data[DATA_W-1:0] = result_q;
			`ASC_OFF_SETTLE: rd_data[PAR_W-1:0] = settle_q;
			default:         rd_ok = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_read_gated: assert property ((state_q == asc_pkg::ASC_IDLE) && cmd_read && !init_q
		|=> (state_q == asc_pkg::ASC_IDLE) && !adc_start) else $error("read ran uninitialised");
	a_acc_clear: assert property ((state_q == asc_pkg::ASC_IDLE) && cmd_read && init_q &&
		!cmd_deact |=> (acc_q == '0) && (cnt_q == '0)) else $error("accumulator not cleared");
	a_settle_taken: assert property ((state_q == asc_pkg::ASC_IDLE) && cmd_read && init_q &&
		!cmd_deact && rev_a_q && (rd_chan != chan_q) && (settle_q == 16'h0002)
		|=> (state_q == asc_pkg::ASC_SETTLE) ##2 adc_start) else $error("settle delay wrong");
	a_sample_grab: assert property ((state_q == asc_pkg::ASC_CONV) && adc_done && init_q
		|=> samp_q == PAR_W'($past(adc_data))) else $error("sample not captured");
	a_mask_apply: assert property ((state_q == asc_pkg::ASC_MASK) && init_q
		|=> samp_q == ($past(samp_q) & $past(mask_q[chan_q]))) else $error("mask not applied");
	a_offset_accum: assert property ((state_q == asc_pkg::ASC_ACCUM) && init_q
		|=> acc_q == $past(acc_q) + (($past(samp_q) < $past(zero_q[chan_q])) ?
		ACC_W'($past(zero_q[chan_q])) : ACC_W'($past(samp_q) - $past(zero_q[chan_q]))))
		else $error("offset correction or sum wrong");
	a_loop_again: assert property ((state_q == asc_pkg::ASC_ACCUM) && init_q && !div_start
		|=> (state_q == asc_pkg::ASC_CONV) && adc_start) else $error("sample loop broken");
	a_result_quot: assert property ((state_q == asc_pkg::ASC_DIV) && div_done && init_q
		|=> done_q && (result_q == (($past(div_quot) > `ASC_RES_MAX) ? `ASC_RES_SAT :
		$past(div_quot[DATA_W-1:0])))) else $error("result not the quotient");
	a_div_time: assert property (div_start && init_q |-> ##33 div_done)
		else $error("divider latency wrong");
	a_line_claim: assert property (cmd_init && !cmd_deact |=> io_adc_sel)
		else $error("line not handed to converter");
	a_line_release: assert property (cmd_deact |=> !io_adc_sel ##1 (state_q == asc_pkg::ASC_IDLE))
		else $error("deactivate did not release");
	a_avg_range: assert property ((avg_q[0] != '0) && (avg_q[0] <= `ASC_AVG_MAX) &&
		(avg_q[1] != '0) && (avg_q[1] <= `ASC_AVG_MAX)) else $error("average count out of range");
	a_zero_range: assert property ((zero_q[0] <= `ASC_ZERO_MAX) && (zero_q[1] <= `ASC_ZERO_MAX))
		else $error("zero offset out of range");

	c_read_done: cover property ((state_q == asc_pkg::ASC_DIV) && div_done);
	c_settle: cover property (state_q == asc_pkg::ASC_SETTLE);
	c_multi_sample: cover property ((state_q == asc_pkg::ASC_ACCUM) && !div_start);
	c_setp_taken: cover property (wr_setp && init_q && (state_q == asc_pkg::ASC_IDLE));

endmodule // asc_top

// ### verif/asc_conv_model.sv
// Behavioural converter that answers each start pulse with one sample.
`timescale 1ns/1ns
module asc_conv_model #(
	parameter int DLY = 3
) (
	input  wire logic        aclk,
	input  wire logic        adc_start,
	output logic             adc_done,
	output logic [11:0]      adc_data
);
	int          w = -1;
	int          n = 0;
	logic [11:0] v;
	initial begin
		adc_done = 1'b0;
		adc_data = 12'hFFF;
	end
	// Data toggles outside the done cycle so a late capture is caught.
	always @(posedge aclk) begin
		if (adc_start === 1'b1)
			w = DLY;
		else if (w > 0)
			w = w - 1;
		if (w == 0) begin
			v = 12'h123 + 12'(n * 12'h245);
			adc_data <= v;
			adc_done <= 1'b1;
			n = n + 1;
			w = -1;
		end else begin
			adc_data <= ~adc_data;
			adc_done <= 1'b0;
		end
	end
endmodule // asc_conv_model

// ### verif/asc_top_tb_top.sv
// Self-checking bench for the converter conditioner over its register bus.
`timescale 1ns/1ns
`include "asc_map.svh"
module asc_top_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        awrdy, wrdy, bvalid, arrdy, rvalid, io_sel, a_start, a_chan, a_done;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, st, v;
	logic [1:0]  bresp, rresp, resp;
	logic [11:0] a_data;
	int          err_count = 0, compares = 0, starts = 0, s0;
	always #50 aclk = ~aclk;
	always @(posedge aclk) if (a_start === 1'b1) starts <= starts + 1;
	asc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .io_adc_sel(io_sel),
		.adc_start(a_start), .adc_chan(a_chan), .adc_done(a_done), .adc_data(a_data));
	asc_conv_model #(.DLY(3)) conv (.aclk(aclk), .adc_start(a_start), .adc_done(a_done),
		.adc_data(a_data));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, fin;
		fin = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (int i = 0; i < 40 && !fin; i++) begin
			@(negedge aclk);
			ta = awvalid && awrdy;
			tw = wvalid && wrdy;
			fin = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		if (!fin) err_count++;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ta, fin;
		fin = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		for (int i = 0; i < 40 && !fin; i++) begin
			@(negedge aclk);
			ta = arvalid && arrdy;
			fin = rvalid;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		if (!fin) err_count++;
	endtask
	task automatic rd_res(output logic [31:0] d);
		for (int i = 0; i < 100; i++) begin
			rd(`ASC_OFF_STATUS, st);
			if (st[3] === 1'b1) break;
		end
		if (st[3] !== 1'b1) err_count++;
		rd(`ASC_OFF_RESULT, d);
	endtask
	function automatic logic [31:0] expv(int k0, int cnt, logic [15:0] m, logic [15:0] z);
		logic [31:0] s;
		logic [15:0] x;
		s = 32'h0;
		for (int k = k0; k < k0 + cnt; k++) begin
			x = {4'h0, 12'h123 + 12'(k * 12'h245)} & m;
			s = s + 32'((x < z) ? z : x - z);
		end
		return s / 32'(cnt);
	endfunction
	task automatic final_report;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`ASC_OFF_STATUS, st);
		chk(st, 32'h0);
		wr(`ASC_OFF_CTRL, 32'h1);
		chk(32'(resp), 32'(`ASC_RESP_OKAY));
		rd(`ASC_OFF_STATUS, st);
		chk(32'(st[0]), 32'h1);
		chk(32'(io_sel), 32'h1);
		wr(`ASC_OFF_CTRL, 32'h4);
		rd_res(v);
		chk(v, expv(0, 1, 16'hFFFF, 16'h0));
		$display("init and default read ended");
		wr(`ASC_OFF_SETP, 32'h0000_0003);
		wr(`ASC_OFF_SETP, 32'h0000_00FF);
		wr(`ASC_OFF_SETP, 32'h0001_0400);
		wr(`ASC_OFF_SETP, 32'h0002_0FF0);
		s0 = starts;
		wr(`ASC_OFF_CTRL, 32'h4);
		rd_res(v);
		chk(32'(starts - s0), 32'h3);
		chk(v, expv(1, 3, 16'h0FF0, 16'h0400));
		wr(`ASC_OFF_CTRL, 32'h10);
		wr(`ASC_OFF_SETTLE, 32'h2);
		rd(`ASC_OFF_SETTLE, v);
		chk(v, 32'h2);
		rd(`ASC_OFF_CTRL, v);
		chk(v, 32'h10);
		wr(`ASC_OFF_CTRL, 32'h1C);
		rd_res(v);
		chk(32'(st[2]), 32'h1);
		chk(32'(a_chan), 32'h1);
		chk(v, expv(4, 1, 16'hFFFF, 16'h0));
		rd(8'h20, v);
		chk(32'(resp), 32'(`ASC_RESP_SLVERR));
		wr(`ASC_OFF_STATUS, 32'h0);
		chk(32'(resp), 32'(`ASC_RESP_SLVERR));
		$display("averaging and channel tests ended");
		wr(`ASC_OFF_CTRL, 32'h2);
		rd(`ASC_OFF_STATUS, st);
		chk(32'(st[0]), 32'h0);
		chk(32'(io_sel), 32'h0);
		s0 = starts;
		wr(`ASC_OFF_CTRL, 32'h4);
		wr(`ASC_OFF_SETP, 32'h0000_0001);
		repeat (20) @(posedge aclk);
		chk(32'(starts - s0), 32'h0);
		wr(`ASC_OFF_CTRL, 32'h1);
		wr(`ASC_OFF_CTRL, 32'h4);
		rd_res(v);
		chk(32'(starts - s0), 32'h3);
		chk(v, expv(5, 3, 16'h0FF0, 16'h0400));
		$display("deactivate test ended");
		final_report();
	end
	initial begin
		#2000000;
		err_count++;
		final_report();
	end
endmodule // asc_top_tb_top
